// *** core/afd_seq.sv ***
/*
 * Fault-diagnostic sequencer of a four-channel amplifier: instruction bits,
 * restart and diagnostic timing, offset and AC tests, fault priority,
 * read-triggered result latching, thermal warnings and mute timing.
 * Assumes the serial framing logic on the same clock delivers written
 * instruction bytes and a one-cycle read-start pulse; sense inputs come
 * from analog comparators and are asynchronous.
 */
// Notes on behaviour
// - Without diagnostics, a shut channel samples its fault each millisecond, reenabling when clear.
// - With diagnostics, an overload lasting past 1 ms runs a 100 ms cycle, then restart.
// - First instruction byte bit 6 enables diagnostics when 1, defeats when 0.
// - Offset test runs from previous read or offset-enable rising until the current read.
// - Excess offset reported only if the offset flag held throughout the test.
// - An overload during measurement suppresses both offset and AC results.
// - AC open-tweeter test active only while second byte bit 2 is 1.
// - Second byte bit 7 picks the high or low current detector pair.
// - Fewer than three detector pulses in the period flags an open tweeter.
// - Of several load faults, the highest-priority ones are reported first; others follow after removal and reads.
// - Shorts to ground or supply outrank shorted and open load; both shorts shown together.
// - A short with the speaker disconnected is a double fault under the same priority.
// - Permanent diagnostics never report open load; only turn-on diagnostics do.
// - A fault is reported only if it held for the whole measurement period.
// - Every host read restarts permanent and offset diagnostic cycles and ends the turn-on window.
// - A read returns results of the preceding cycle, so changes show on the second read.
// - Three thermal warnings are carried in the read-back data.
// - With second byte bit 5 set, a mute transition completes in under 1.5 ms.
module afd_seq #(
    parameter int SAMP_CYC  = afd_pkg::SAMPLE_CYC,
    parameter int DG_CYC    = afd_pkg::DIAG_CYC,
    parameter int FAST_CYC  = afd_pkg::FAST_MUTE_CYC,
    parameter int NORM_CYC  = afd_pkg::NORM_MUTE_CYC
) (
    // Clock and reset
    input  wire logic                                 ref_clk_i,
    input  wire logic                                 reset_i,
    // Instruction writes and read start from the serial framing logic
    input  wire afd_pkg::afd_ib_wr_t                  ib_wr_i,
    input  wire logic                                 read_i,
    // Asynchronous analog sense levels
    input  wire afd_pkg::afd_sense_t [afd_pkg::N_CH-1:0] sense_i,
    input  wire logic [afd_pkg::N_THERM-1:0]          thermal_i,
    // Diagnostic read-back
    output afd_pkg::afd_diag_t                        diag_o,
    output logic                                      diag_valid_o,
    // Channel and mute status
    output logic [afd_pkg::N_CH-1:0]                  chan_on_o,
    output logic [afd_pkg::N_CH-1:0]                  diag_busy_o,
    output logic [1:0]                                mute_o,
    output logic [1:0]                                mute_busy_o
);
    import afd_pkg::*;

    if (SAMP_CYC < 1 || DG_CYC < 1 || FAST_CYC < 1 || NORM_CYC < 1 ||
        SAMP_CYC >= 2**CNT_W || DG_CYC >= 2**CNT_W || NORM_CYC >= 2**CNT_W || FAST_CYC >= NORM_CYC) begin : g_bad
        $error("afd_seq: cycle counts out of range");
    end

    localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_CYC - 1);
    localparam logic [CNT_W-1:0] NORM_LAST = CNT_W'(NORM_CYC - 1);
    localparam int SW = $bits(afd_sense_t);

    // Synchronised sense levels.
    logic [N_CH*SW+N_THERM-1:0] sync_w;
    afd_sense_t [N_CH-1:0]      sense_s;
    logic [N_THERM-1:0]         therm_s;

    afd_sync #(
        .W (N_CH*SW+N_THERM)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({sense_i, thermal_i}),
        .sync_o    (sync_w)
    );

    assign sense_s = sync_w[N_CH*SW+N_THERM-1:N_THERM];
    assign therm_s = sync_w[N_THERM-1:0];

    // Instruction bytes and their previous values for edge detection.
    logic [7:0] ib1_reg, ib1_next;
    logic [7:0] ib2_reg, ib2_next;
    logic [7:0] ib1_d_reg;
    logic [7:0] ib2_d_reg;
    logic       turnon_reg, turnon_next;
    logic [1:0] settle_reg, settle_next;
    logic       settled;

    always_comb begin
        ib1_next = ib1_reg;
        ib2_next = ib2_reg;
        settle_next = {settle_reg[0], 1'b1};
        if (ib_wr_i.wr && !ib_wr_i.sel) begin
            ib1_next = ib_wr_i.data;
        end
        if (ib_wr_i.wr && ib_wr_i.sel) begin
            ib2_next = ib_wr_i.data;
        end
        // Turn-on window opens when diagnostics get enabled and ends at the read.
        turnon_next = turnon_reg;
        if (read_i) begin
            turnon_next = 1'b0;
        end
        if (ib1_reg[IB1_DIAG_EN] && !ib1_d_reg[IB1_DIAG_EN]) begin
            turnon_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ib1_reg    <= IB_RESET;
            ib2_reg    <= IB_RESET;
            ib1_d_reg  <= IB_RESET;
            ib2_d_reg  <= IB_RESET;
            turnon_reg <= 1'b0;
            settle_reg <= 2'h0;
        end else begin
            ib1_reg    <= ib1_next;
            ib2_reg    <= ib2_next;
            ib1_d_reg  <= ib1_reg;
            ib2_d_reg  <= ib2_reg;
            turnon_reg <= turnon_next;
            settle_reg <= settle_next;
        end
    end

    logic diag_en;
    logic offs_en;
    logic ac_en;
    logic thr_low;
    logic offs_start;
    logic ac_start;

    assign diag_en    = ib1_reg[IB1_DIAG_EN];
    assign offs_en    = ib1_reg[IB1_OFFS_EN];
    assign ac_en      = ib2_reg[IB2_AC_EN];
    assign thr_low    = ib2_reg[IB2_THR_LOW];
    assign offs_start = ib1_reg[IB1_OFFS_EN] & ~ib1_d_reg[IB1_OFFS_EN];
    assign ac_start   = ib2_reg[IB2_AC_EN] & ~ib2_d_reg[IB2_AC_EN];
    // Synchronised levels read zero for two cycles after reset and must not clear faults.
    assign settled    = settle_reg[1];

    afd_chres_t [N_CH-1:0] res_all;

    for (genvar c = 0; c < N_CH; c++) begin : ch_g
        afd_sense_t s;
        logic       ipk;
        logic [3:0] stab_reg, stab_next;
        logic       offs_reg, offs_next;
        logic       ovl_reg, ovl_next;
        logic [1:0] pcnt_reg, pcnt_next;
        logic       ipk_d_reg;
        logic       ipk_rise;
        logic       sg, sv;
        afd_chres_t res_reg, res_next;

        assign s   = sense_s[c];
        // The chosen pair only moves the analog threshold; the count is the same.
        assign ipk = thr_low ? s.ipk_lo : s.ipk_hi;
        assign ipk_rise = ipk & ~ipk_d_reg;
        assign sg  = stab_reg[3];
        assign sv  = stab_reg[2];

        always_comb begin
            // Each fault bit is the AND of every sample since the last read.
            stab_next = stab_reg & {s.sgnd, s.svs, s.sload, s.oload};
            offs_next = offs_reg & s.offs;
            if (!settled) begin
                stab_next = stab_reg;
                offs_next = offs_reg;
            end
            ovl_next  = ovl_reg | s.ovl;
            pcnt_next = pcnt_reg;
            if (ipk_rise && pcnt_reg != AC_MIN_PULSES) begin
                pcnt_next = pcnt_reg + 2'h1;
            end
            if (offs_start) begin
                offs_next = 1'b1;
            end
            if (ac_start) begin
                pcnt_next = {1'b0, ipk_rise};
            end
            res_next = res_reg;
            if (read_i) begin
                res_next.sgnd    = diag_en & sg;
                res_next.svs     = diag_en & sv;
                res_next.sload   = diag_en & stab_reg[1] & ~sg & ~sv;
                // Open load only inside the turn-on window, lowest priority.
                res_next.oload   = diag_en & turnon_reg & stab_reg[0] & ~stab_reg[1] & ~sg & ~sv;
                res_next.offs    = offs_en & offs_reg & ~ovl_reg;
                res_next.open_tw = ac_en & ~ovl_reg & (pcnt_reg < AC_MIN_PULSES);
                stab_next = 4'hf;
                offs_next = 1'b1;
                ovl_next  = s.ovl;
                pcnt_next = {1'b0, ipk_rise};
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                stab_reg  <= 4'hf;
                offs_reg  <= 1'b1;
                ovl_reg   <= 1'b0;
                pcnt_reg  <= 2'h0;
                ipk_d_reg <= 1'b0;
                res_reg   <= '0;
            end else begin
                stab_reg  <= stab_next;
                offs_reg  <= offs_next;
                ovl_reg   <= ovl_next;
                pcnt_reg  <= pcnt_next;
                ipk_d_reg <= ipk;
                res_reg   <= res_next;
            end
        end

        assign res_all[c] = res_reg;

        afd_restart_fsm #(
            .SAMP_CYC (SAMP_CYC),
            .DG_CYC   (DG_CYC)
        ) u_fsm (
            .ref_clk_i   (ref_clk_i),
            .reset_i     (reset_i),
            .diag_en_i   (diag_en),
            .rearm_i     (read_i),
            .ovl_i       (s.ovl),
            .chan_on_o   (chan_on_o[c]),
            .diag_busy_o (diag_busy_o[c])
        );
    end

    // Thermal warnings and read-back snapshot.
    logic [N_THERM-1:0] therm_seen_reg, therm_seen_next;
    logic [N_THERM-1:0] therm_res_reg, therm_res_next;
    afd_diag_t          diag_reg, diag_next;
    logic               valid_reg, valid_next;

    always_comb begin
        therm_seen_next = therm_seen_reg | therm_s;
        therm_res_next  = therm_res_reg;
        diag_next       = diag_reg;
        valid_next      = read_i;
        if (read_i) begin
            // Bytes leave from this copy of the previous cycle's results.
            diag_next.thermal = therm_res_reg;
            diag_next.ch      = res_all;
            therm_res_next    = therm_seen_reg;
            therm_seen_next   = therm_s;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            therm_seen_reg <= '0;
            therm_res_reg  <= '0;
            diag_reg       <= '0;
            valid_reg      <= 1'b0;
        end else begin
            therm_seen_reg <= therm_seen_next;
            therm_res_reg  <= therm_res_next;
            diag_reg       <= diag_next;
            valid_reg      <= valid_next;
        end
    end

    assign diag_o       = diag_reg;
    assign diag_valid_o = valid_reg;

    // Mute timing per channel pair: index 0 rear, index 1 front.
    for (genvar p = 0; p < 2; p++) begin : mute_g
        localparam int UB = (p == 0) ? IB1_UNMUTE_REAR : IB1_UNMUTE_FRONT;
        logic [CNT_W-1:0] cnt_reg, cnt_next;
        logic             mute_reg, mute_next;
        logic             busy_reg, busy_next;
        logic             fast;
        logic             at_end;

        assign fast   = ib2_reg[IB2_FAST_MUTE];
        // Fast setting mid-transition shortens what is left of it.
        assign at_end = (cnt_reg >= (fast ? FAST_LAST : NORM_LAST));

        always_comb begin
            cnt_next  = cnt_reg;
            mute_next = mute_reg;
            busy_next = busy_reg;
            if (ib1_reg[UB]) begin
                mute_next = 1'b0;
                busy_next = 1'b0;
                cnt_next  = '0;
            end else if (!mute_reg && !busy_reg) begin
                busy_next = 1'b1;
                cnt_next  = '0;
            end else if (busy_reg) begin
                cnt_next = cnt_reg + 1'b1;
                if (at_end) begin
                    busy_next = 1'b0;
                    mute_next = 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                cnt_reg  <= '0;
                mute_reg <= 1'b1;
                busy_reg <= 1'b0;
            end else begin
                cnt_reg  <= cnt_next;
                mute_reg <= mute_next;
                busy_reg <= busy_next;
            end
        end

        assign mute_o[p]      = mute_reg;
        assign mute_busy_o[p] = busy_reg;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_DIAG_EN_BIT: assert property (
        ib_wr_i.wr && !ib_wr_i.sel |=> diag_en == $past(ib_wr_i.data[IB1_DIAG_EN]))
        else $error("diagnostic enable does not follow the first byte");
    AST_READ_PREVIOUS: assert property (
        read_i |=> diag_o.ch == $past(res_all) && diag_valid_o)
        else $error("read did not return the previous results");
    AST_SNAPSHOT_HOLD: assert property (
        !read_i |=> $stable(diag_o))
        else $error("read-back data changed without a read");
    AST_OFFS_PERSIST: assert property (
        read_i && !ch_g[0].offs_reg |=> !ch_g[0].res_reg.offs)
        else $error("transient offset reported");
    AST_OVL_SUPPRESS: assert property (
        read_i && ch_g[3].ovl_reg |=> !ch_g[3].res_reg.offs && !ch_g[3].res_reg.open_tw)
        else $error("overload did not suppress results");
    AST_AC_PULSES: assert property (
        read_i && ac_en && !ch_g[1].ovl_reg && ch_g[1].pcnt_reg < 2'h3 |=> ch_g[1].res_reg.open_tw)
        else $error("open tweeter not flagged");
    AST_AC_DISABLED: assert property (
        read_i && !ac_en |=> !ch_g[1].res_reg.open_tw)
        else $error("open tweeter flagged with test off");
    AST_SHORT_PRIO: assert property (
        ch_g[2].res_reg.sgnd || ch_g[2].res_reg.svs |-> !ch_g[2].res_reg.sload && !ch_g[2].res_reg.oload)
        else $error("short did not outrank load fault");
    AST_NO_PERM_OPEN: assert property (
        read_i && !turnon_reg |=> !ch_g[3].res_reg.oload)
        else $error("open load reported outside turn-on window");
    AST_RESTART_ON_READ: assert property (
        read_i |=> ch_g[0].stab_reg == 4'hf && ch_g[0].pcnt_reg == {1'b0, $past(ch_g[0].ipk_rise)} &&
            ch_g[0].ovl_reg == $past(ch_g[0].s.ovl))
        else $error("read did not restart measurement");

    logic fast_mute_guard;
    assign fast_mute_guard = ib2_reg[IB2_FAST_MUTE] && ib2_d_reg[IB2_FAST_MUTE] && mute_g[0].busy_reg;

    AST_FAST_MUTE: assert property (
        fast_mute_guard |-> mute_g[0].cnt_reg <= FAST_LAST)
        else $error("fast mute transition too long");

    COV_READ_FAULT: cover property (read_i ##1 diag_o.ch[0].sgnd);
    COV_OPEN_TWEETER: cover property (read_i ##1 diag_o.ch[1].open_tw);
    COV_OFFSET: cover property (read_i ##1 diag_o.ch[0].offs);
    COV_MUTE_DONE: cover property (mute_busy_o[1] ##1 mute_o[1]);

endmodule : afd_seq

// *** core/afd_pkg.sv ***
/*
 * Shared constants and types of the amplifier fault-diagnostic sequencer.
 * Assumes a single 50 MHz system clock; all counts derive from its period.
 */
package afd_pkg;

    // Clock and timing, each time in its own unit.
    localparam int CLK_PERIOD_NS    = 20;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int DIAG_CYCLE_MS    = 100;
    localparam int FAST_MUTE_US     = 1500;
    localparam int NORM_MUTE_MS     = 20;
    localparam int SAMPLE_CYC       = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int DIAG_CYC         = DIAG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    // Strictly under the fast limit, hence one cycle less.
    localparam int FAST_MUTE_CYC    = FAST_MUTE_US * 1000 / CLK_PERIOD_NS - 1;
    localparam int NORM_MUTE_CYC    = NORM_MUTE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W            = 24;

    // Instruction byte fields.
    localparam int IB1_UNMUTE_REAR  = 1;
    localparam int IB1_UNMUTE_FRONT = 2;
    localparam int IB1_OFFS_EN      = 5;
    localparam int IB1_DIAG_EN      = 6;
    localparam int IB2_AC_EN        = 2;
    localparam int IB2_FAST_MUTE    = 5;
    localparam int IB2_THR_LOW      = 7;
    localparam logic [7:0] IB_RESET = 8'h00;

    localparam int N_CH             = 4;
    localparam int N_THERM          = 3;
    localparam logic [1:0] AC_MIN_PULSES = 2'h3;

    typedef enum logic [1:0] {
        ST_RUN     = 2'h0,
        ST_CHECK   = 2'h1,
        ST_DIAG    = 2'h3,
        ST_RESTART = 2'h2
    } afd_state_t;

    typedef struct packed {
        logic sgnd;
        logic svs;
        logic sload;
        logic oload;
        logic ovl;
        logic offs;
        logic ipk_hi;
        logic ipk_lo;
    } afd_sense_t;

    typedef struct packed {
        logic sgnd;
        logic svs;
        logic sload;
        logic oload;
        logic offs;
        logic open_tw;
    } afd_chres_t;

    typedef struct packed {
        logic [N_THERM-1:0]    thermal;
        afd_chres_t [N_CH-1:0] ch;
    } afd_diag_t;

    typedef struct packed {
        logic       wr;
        logic       sel;
        logic [7:0] data;
    } afd_ib_wr_t;

endpackage : afd_pkg

// *** core/afd_sync.sv ***
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is a slow level; no bus coherency is implied.
 */
module afd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : afd_sync

// *** core/afd_restart_fsm.sv ***
/*
 * Per-channel restart and permanent-diagnostic sequencer.
 * Assumes a synchronised overload level and a one-cycle read pulse.
 */
module afd_restart_fsm #(
    parameter int SAMP_CYC = afd_pkg::SAMPLE_CYC,
    parameter int DG_CYC   = afd_pkg::DIAG_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // Control
    input  wire logic diag_en_i,
    input  wire logic rearm_i,
    input  wire logic ovl_i,
    // Status
    output logic      chan_on_o,
    output logic      diag_busy_o
);
    import afd_pkg::*;

    localparam logic [CNT_W-1:0] S_LAST = CNT_W'(SAMP_CYC - 1);
    localparam logic [CNT_W-1:0] D_LAST = CNT_W'(DG_CYC - 1);

    afd_state_t       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             armed_reg, armed_next;
    logic             on_reg, on_next;
    logic             busy_reg, busy_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 1'b1;
        armed_next = armed_reg | rearm_i;
        unique case (state_reg)
            ST_RUN: begin
                cnt_next = '0;
                if (ovl_i) begin
                    state_next = (diag_en_i && armed_reg) ? ST_CHECK : ST_RESTART;
                end
            end
            ST_CHECK: begin
                if (cnt_reg == S_LAST) begin
                    cnt_next   = '0;
                    state_next = ovl_i ? ST_DIAG : ST_RUN;
                end
            end
            ST_DIAG: begin
                if (cnt_reg == D_LAST) begin
                    cnt_next   = '0;
                    state_next = ST_RESTART;
                    // A new cycle waits for the next host read.
                    armed_next = rearm_i;
                end
            end
            ST_RESTART: begin
                if (cnt_reg == S_LAST) begin
                    cnt_next = '0;
                    if (!ovl_i) begin
                        state_next = ST_RUN;
                    end
                end
            end
        endcase
        on_next   = (state_next == ST_RUN);
        busy_next = (state_next == ST_DIAG);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_RUN;
            cnt_reg   <= '0;
            armed_reg <= 1'b1;
            on_reg    <= 1'b1;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            armed_reg <= armed_next;
            on_reg    <= on_next;
            busy_reg  <= busy_next;
        end
    end

    assign chan_on_o   = on_reg;
    assign diag_busy_o = busy_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_RESTART_SAMPLE: assert property (
        state_reg == ST_RESTART && cnt_reg != S_LAST |=> state_reg == ST_RESTART)
        else $error("restart left between samples");
    AST_DIAG_TO_RESTART: assert property (
        state_reg == ST_DIAG && cnt_reg == D_LAST |=> state_reg == ST_RESTART && !on_reg)
        else $error("diagnostic cycle did not end in restart");

endmodule : afd_restart_fsm

// *** tb/afd_host_model.sv ***
/*
 * Host model: writes instruction bytes and starts diagnostic reads.
 * Assumes the sequencer samples both strobes on rising clock edges.
 */
module afd_host_model (
    input  wire logic          ref_clk_i,
    output afd_pkg::afd_ib_wr_t ib_wr_o,
    output logic               read_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import afd_pkg::*;

    initial begin
        ib_wr_o = '0;
        read_o  = 1'b0;
    end

    // Each strobe lasts one cycle, so the next request waits one idle cycle.
    task automatic write_ib(input logic sel, input logic [7:0] data);
        @(posedge ref_clk_i);
        #1 ib_wr_o = '{wr: 1'b1, sel: sel, data: data};
        @(posedge ref_clk_i);
        #1 ib_wr_o = '0;
    endtask : write_ib

    task automatic start_read();
        @(posedge ref_clk_i);
        #1 read_o = 1'b1;
        @(posedge ref_clk_i);
        #1 read_o = 1'b0;
    endtask : start_read
endmodule : afd_host_model

// *** tb/tb_top.sv ***
/*
 * Self-checking bench of the fault-diagnostic sequencer with short counts.
 * Assumes the host model drives writes and reads; sense levels come from here.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import afd_pkg::*;

    logic                  ref_clk_i = 1'b0;
    logic                  reset_i   = 1'b1;
    afd_ib_wr_t            ib_wr;
    logic                  rd;
    afd_sense_t [N_CH-1:0] sense     = '0;
    logic [N_THERM-1:0]    thermal   = 3'h5;
    afd_diag_t             diag;
    logic                  diag_valid;
    logic [N_CH-1:0]       chan_on;
    logic [N_CH-1:0]       diag_busy;
    logic [1:0]            mute;
    logic [1:0]            mute_busy;
    int                    mismatches  = 0;
    int                    comparisons = 0;
    int                    n;
    int                    nf;

    initial forever #10 ref_clk_i = ~ref_clk_i;

    afd_host_model host (.ref_clk_i(ref_clk_i), .ib_wr_o(ib_wr), .read_o(rd));

    afd_seq #(.SAMP_CYC(10), .DG_CYC(50), .FAST_CYC(5), .NORM_CYC(20)) dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ib_wr_i(ib_wr), .read_i(rd),
        .sense_i(sense), .thermal_i(thermal), .diag_o(diag), .diag_valid_o(diag_valid),
        .chan_on_o(chan_on), .diag_busy_o(diag_busy), .mute_o(mute), .mute_busy_o(mute_busy));

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    task automatic check_diag(input afd_diag_t exp);
        comparisons++;
        if (diag !== exp || diag_valid !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: diag %h expected %h", $time, diag, exp);
        end
    endtask : check_diag

    task automatic check_flag(input logic got, input string what);
        comparisons++;
        if (got !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check_flag

    // Counts cycles until the chosen status shows, giving up at the limit.
    task automatic wait_for(input int sel, input int lim);
        n = 0;
        while (n < lim && !(sel == 0 ? diag_busy[3] === 1'b1 : sel == 1 ? chan_on[3] === 1'b1 : mute === 2'h3)) begin
            @(posedge ref_clk_i);
            #1 n++;
        end
    endtask : wait_for

    // Current-detector pulses at the 160 ns link rate.
    task automatic pulses(input int k);
        repeat (k) begin
            @(posedge ref_clk_i);
            #1 sense[3].ipk_hi = 1'b1;
            repeat (4) @(posedge ref_clk_i);
            #1 sense[3].ipk_hi = 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask : pulses

    initial begin
        #100us;
        mismatches++;
        summarize();
    end

    initial begin
        sense[0].sgnd  = 1'b1;
        sense[0].svs   = 1'b1;
        sense[0].sload = 1'b1;
        sense[1].sload = 1'b1;
        sense[1].oload = 1'b1;
        sense[1].offs  = 1'b1;
        sense[2].oload = 1'b1;
        repeat (6) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        check_flag(chan_on === 4'hf && mute === 2'h3, "reset status");
        host.write_ib(1'b0, 8'h60);
        host.write_ib(1'b1, 8'h04);
        pulses(3);
        host.start_read();
        check_diag('0);
        pulses(2);
        host.start_read();
        check_diag({3'h5, 6'h00, 6'h05, 6'h0b, 6'h31});
        host.start_read();
        check_diag({3'h5, 6'h01, 6'h01, 6'h0b, 6'h31});
        for (int i = 0; i < N_CH; i++) begin
            sense[i] = '0;
        end
        // Cleared levels need two cycles through the synchroniser.
        repeat (2) @(posedge ref_clk_i);
        host.start_read();
        check_diag({3'h5, 6'h01, 6'h01, 6'h0b, 6'h31});
        host.start_read();
        check_diag({3'h5, 6'h01, 6'h01, 6'h01, 6'h01});
        $display("test reads done");
        sense[3].ovl = 1'b1;
        wait_for(0, 30);
        check_flag(n < 30 && chan_on[3] === 1'b0, "no diagnostic cycle");
        sense[3].ovl = 1'b0;
        wait_for(1, 100);
        check_flag(n < 100, "channel not restored");
        host.write_ib(1'b0, 8'h00);
        sense[3].ovl = 1'b1;
        repeat (30) @(posedge ref_clk_i);
        #1 check_flag(diag_busy[3] === 1'b0 && chan_on[3] === 1'b0, "restart state");
        sense[3].ovl = 1'b0;
        wait_for(1, 25);
        check_flag(n < 25, "restart sampling slow");
        $display("test restart done");
        host.write_ib(1'b0, 8'h06);
        repeat (4) @(posedge ref_clk_i);
        #1 check_flag(mute === 2'h0, "unmute");
        host.write_ib(1'b1, 8'h20);
        host.write_ib(1'b0, 8'h00);
        wait_for(2, 40);
        nf = n;
        check_flag(nf < 9, "fast mute slow");
        host.write_ib(1'b1, 8'h00);
        host.write_ib(1'b0, 8'h06);
        repeat (4) @(posedge ref_clk_i);
        host.write_ib(1'b0, 8'h00);
        repeat (2) @(posedge ref_clk_i);
        #1 check_flag(mute_busy === 2'h3 && mute === 2'h0, "mute transition busy");
        wait_for(2, 40);
        check_flag(n >= 15 && n < 30 && nf < n, "normal mute time");
        host.start_read();
        check_diag({3'h5, 6'h01, 6'h01, 6'h01, 6'h01});
        host.start_read();
        check_diag({3'h5, 24'h0});
        $display("test mute done");
        summarize();
    end
endmodule : tb_top
